/* design/nested_priority_interrupt_controller.sv */
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
//
// Overview of operation
// - Two-bit level code; level 3 masks
// - Level bits sit at CC bits 5,3
// - Service only at instruction boundary
// - Maskable and trap entries stack registers
// - Entry loads level from vector priority
// - Program counter loads the source's own vector
// - Return restores stacked CC level bits
// - Highest software level, then hardware order
// - Unserviced edge requests stay latched pending
// - Enabled and strictly above current level
// - Reset, trap ignore level, win arbitration
// - Non-maskable forces level 3, stacks
// - Reset runs first routine at level 3
// - Non-maskable sources leave deep stop
// - Trap instruction raises serviced trap
// - Edge requests latched, cleared on entry
// - Pins sharing a line are ORed
// - Flag and enable request; clear drops it
// - All wake wait; wake-capable leave stop
// - After stop, first service is wake-capable
// - Level bits written by CC instructions
// - Sixteen vectors, four levels, no overflow
// - Enable loads 10, disable loads 11
// - Level 0 writes ignored; reset all ones
//
module nested_priority_interrupt_controller
  import nic_pkg::*;
#(
  parameter int PINS_PER_LINE = 4
) (
  input  wire logic                     I_SYS_CLK,
  input  wire logic                     I_RESET_N,
  input  wire cpu_evt_t                 I_CPU_EVT,
  input  wire logic [NUM_VEC-1:0]       I_PERIPH_REQ,
  input  wire logic [NUM_VEC-1:0]       I_PERIPH_CLEAR,
  input  wire logic [NUM_VEC*PINS_PER_LINE-1:0] I_EXT_PINS,
  output vec_req_t                      O_VEC,
  output logic [7:0]                    O_CC,
  output logic                          O_WAKE,
  input  wire logic [7:0]               I_AWADDR,
  input  wire logic                     I_AWVALID,
  output logic                          O_AWREADY,
  input  wire logic [31:0]              I_WDATA,
  input  wire logic [3:0]               I_WSTRB,
  input  wire logic                     I_WVALID,
  output logic                          O_WREADY,
  output logic [1:0]                    O_BRESP,
  output logic                          O_BVALID,
  input  wire logic                     I_BREADY,
  input  wire logic [7:0]               I_ARADDR,
  input  wire logic                     I_ARVALID,
  output logic                          O_ARREADY,
  output logic [31:0]                   O_RDATA,
  output logic [1:0]                    O_RRESP,
  output logic                          O_RVALID,
  input  wire logic                     I_RREADY
);

  initial begin
    if (PINS_PER_LINE < 1 || NUM_VEC > 16)
      $error("Unsupported controller configuration");
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  svc_state_t                  state;
  logic [7:0]                  cc;
  logic [7:0]                  prio_reg [NUM_PRIO_REG];
  logic [NUM_VEC-1:0]          enable;
  logic [NUM_VEC-1:0]          wake_cap;
  logic [NUM_VEC-1:0]          edge_mode;
  logic [NUM_VEC-1:0]          ext_pend;
  logic [NUM_VEC-1:0]          ext_prev;
  logic [NUM_VEC-1:0]          ext_line;
  logic [NUM_VEC-1:0]          request;
  logic                        trap_pend;
  logic                        from_stop;

  logic [1:0]                  cur_code;
  logic [1:0]                  vec_code [NUM_VEC];
  logic [2:0]                  vec_rank [NUM_VEC];
  logic [2:0]                  cur_rank;
  logic [1:0]                  eff_code;

  function automatic logic [2:0] rank(input logic [1:0] code);
    unique case (code)
      LVL0_CODE: rank = 3'h0;
      LVL1_CODE: rank = 3'h1;
      LVL2_CODE: rank = 3'h2;
      LVL3_CODE: rank = 3'h3;
    endcase
  endfunction

  assign cur_code = {cc[CC_BIT_HIGH], cc[CC_BIT_LOW]};

  // Arbitrate against the level the completed instruction leaves, so
  // an enable that unmasks a pending request is answered at once
  always_comb begin
    eff_code = cur_code;
    if (I_CPU_EVT.boundary) begin
      if (I_CPU_EVT.return_from_interrupt || I_CPU_EVT.pop_cc)
        eff_code = {I_CPU_EVT.cc_value[CC_BIT_HIGH],
                    I_CPU_EVT.cc_value[CC_BIT_LOW]};
      else if (I_CPU_EVT.enable_int || I_CPU_EVT.wait_for_interrupt_instr ||
               I_CPU_EVT.deep_stop)
        eff_code = LVL0_CODE;
      else if (I_CPU_EVT.disable_int)
        eff_code = LVL3_CODE;
    end
  end
  assign cur_rank = rank(eff_code);

  // ------------------------------------------------------------
  // Request sources
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_VEC; g++) begin : g_vec
      assign ext_line[g] =
        |I_EXT_PINS[g*PINS_PER_LINE +: PINS_PER_LINE];
      assign vec_code[g] = prio_reg[g/4][(g%4)*2 +: 2];
      assign vec_rank[g] = rank(vec_code[g]);
      // Level lines follow the pin; edges use the latch
      assign request[g] = I_PERIPH_REQ[g] |
        (edge_mode[g] ? ext_pend[g] : ext_line[g]);
    end
  endgenerate

  // ------------------------------------------------------------
  // Arbitration
  // ------------------------------------------------------------
  logic              found;
  logic              found_wake;
  logic [3:0]        win_idx;
  logic [3:0]        wake_idx;
  logic [2:0]        best;
  logic [2:0]        best_wake;
  logic              eligible;

  always_comb begin
    found      = 1'b0;
    found_wake = 1'b0;
    win_idx    = 4'h0;
    wake_idx   = 4'h0;
    best       = 3'h0;
    best_wake  = 3'h0;
    eligible   = 1'b0;
    // Lowest index is highest hardware priority; strict > keeps it
    for (int i = 0; i < NUM_VEC; i++) begin
      eligible = request[i] & enable[i] &
                 (vec_rank[i] > cur_rank);
      if (eligible && (!found || vec_rank[i] > best)) begin
        found   = 1'b1;
        best    = vec_rank[i];
        win_idx = 4'(i);
      end
      if (eligible && wake_cap[i] &&
          (!found_wake || vec_rank[i] > best_wake)) begin
        found_wake = 1'b1;
        best_wake  = vec_rank[i];
        wake_idx   = 4'(i);
      end
    end
  end

  logic any_wake;
  assign any_wake = found_wake | trap_pend;

  // ------------------------------------------------------------
  // Service sequencer
  // ------------------------------------------------------------
  logic       take_int;
  logic [3:0] take_idx;
  // Only the first maskable entry after stop is restricted to wake sources
  assign take_int = from_stop ? found_wake : found;
  assign take_idx = from_stop ? wake_idx : win_idx;

  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state <= ST_RESET;
      O_VEC <= '0;
      O_WAKE <= 1'b0;
      from_stop <= 1'b0;
    end else begin
      O_VEC.take <= 1'b0;
      unique case (state)
        ST_RESET: begin
          O_VEC <= '{take: 1'b1, stack: 1'b0,
                     addr: VEC_RESET, index: 4'hF};
          state <= ST_RUN;
        end
        ST_RUN: begin
          O_WAKE <= 1'b0;
          if (I_CPU_EVT.boundary) begin
            if (trap_pend || I_CPU_EVT.trap) begin
              O_VEC <= '{take: 1'b1, stack: 1'b1,
                         addr: VEC_TRAP, index: 4'hE};
              state <= ST_VECTOR;
            end else if (take_int) begin
              O_VEC <= '{take: 1'b1, stack: 1'b1,
                         addr: 16'(VEC_BASE - {take_idx, 1'b0}),
                         index: take_idx};
              from_stop <= 1'b0;
              state <= ST_VECTOR;
            end else if (I_CPU_EVT.wait_for_interrupt_instr) begin
              state <= ST_WAIT;
            end else if (I_CPU_EVT.deep_stop) begin
              state <= ST_STOP;
            end
          end
        end
        ST_WAIT: begin
          if (found || trap_pend) begin
            O_WAKE <= 1'b1;
            state <= ST_RUN;
          end
        end
        ST_STOP: begin
          if (any_wake) begin
            O_WAKE <= 1'b1;
            from_stop <= 1'b1;
            state <= ST_RUN;
          end
        end
        ST_VECTOR: begin
          // A non-waking winner left behind is rearbitrated next boundary
          state <= ST_RUN;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Trap latch
  // ------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      trap_pend <= 1'b0;
    end else if (state == ST_RUN && I_CPU_EVT.boundary) begin
      trap_pend <= 1'b0;
    end else if (I_CPU_EVT.trap) begin
      trap_pend <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // External edge latches
  // ------------------------------------------------------------
  logic entering;
  assign entering = state == ST_RUN && I_CPU_EVT.boundary &&
                    !(trap_pend || I_CPU_EVT.trap) && take_int;

  generate
    for (g = 0; g < NUM_VEC; g++) begin : g_edge
      always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
          ext_prev[g] <= 1'b0;
          ext_pend[g] <= 1'b0;
        end else begin
          ext_prev[g] <= ext_line[g];
          // A new edge wins over the entry clear
          if (ext_line[g] && !ext_prev[g])
            ext_pend[g] <= 1'b1;
          else if ((entering && take_idx == 4'(g)) ||
                   I_PERIPH_CLEAR[g])
            ext_pend[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Condition code level bits
  // ------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      cc <= CC_RESET;
    end else if (state == ST_RESET) begin
      cc[CC_BIT_HIGH] <= LVL3_CODE[1];
      cc[CC_BIT_LOW]  <= LVL3_CODE[0];
    end else if (state == ST_RUN && I_CPU_EVT.boundary) begin
      if (trap_pend || I_CPU_EVT.trap) begin
        cc[CC_BIT_HIGH] <= LVL3_CODE[1];
        cc[CC_BIT_LOW]  <= LVL3_CODE[0];
      end else if (take_int) begin
        cc[CC_BIT_HIGH] <= vec_code[take_idx][1];
        cc[CC_BIT_LOW]  <= vec_code[take_idx][0];
      end else if (I_CPU_EVT.return_from_interrupt || I_CPU_EVT.pop_cc) begin
        cc <= I_CPU_EVT.cc_value;
      end else begin
        cc[CC_BIT_HIGH] <= eff_code[1];
        cc[CC_BIT_LOW]  <= eff_code[0];
      end
    end
  end

  assign O_CC = cc;

  // ------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic       do_write;

  assign do_write = aw_held && w_held && !O_BVALID;

  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      O_AWREADY <= 1'b0;
      O_WREADY <= 1'b0;
      O_BVALID <= 1'b0;
      O_BRESP <= RESP_OKAY;
    end else begin
      // Ready stays low from acceptance until the response is issued
      O_AWREADY <= !aw_held && !(I_AWVALID && O_AWREADY);
      O_WREADY <= !w_held && !(I_WVALID && O_WREADY);
      if (I_AWVALID && O_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY) begin
        w_held <= 1'b1;
        w_data <= I_WDATA;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        O_BVALID <= 1'b1;
        O_BRESP <= (aw_addr <= ADDR_STATUS && aw_addr[1:0] == 2'h0)
                   ? RESP_OKAY : RESP_SLVERR;
      end else if (O_BVALID && I_BREADY) begin
        O_BVALID <= 1'b0;
      end
    end
  end

  // Software priority fields; level-0 codes keep the old pair
  generate
    for (g = 0; g < NUM_PRIO_REG; g++) begin : g_prio
      always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
          prio_reg[g] <= PRIO_RESET;
        end else if (do_write && I_WSTRB[0] &&
                     aw_addr == 8'(ADDR_PRIO0 + 4*g)) begin
          for (int k = 0; k < 4; k++) begin
            if (w_data[k*2 +: 2] != LVL0_CODE)
              prio_reg[g][k*2 +: 2] <= w_data[k*2 +: 2];
          end
          // Upper half of the last register holds no vectors
          if (g == NUM_PRIO_REG - 1)
            prio_reg[g][7:4] <= PRIO_RESET[7:4];
        end
      end
    end
  endgenerate

  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      enable <= '0;
      wake_cap <= '0;
      edge_mode <= '0;
    end else if (do_write) begin
      if (aw_addr == ADDR_ENABLE)
        enable <= w_data[NUM_VEC-1:0];
      if (aw_addr == ADDR_WAKE)
        wake_cap <= w_data[NUM_VEC-1:0];
      if (aw_addr == ADDR_EDGE)
        edge_mode <= w_data[NUM_VEC-1:0];
    end
  end

  logic [31:0] rd_mux;
  logic        rd_ok;
  always_comb begin
    rd_mux = 32'h0;
    rd_ok  = 1'b1;
    unique case (I_ARADDR)
      8'h00, 8'h04, 8'h08, 8'h0C:
        rd_mux = {24'h0, prio_reg[I_ARADDR[3:2]]};
      ADDR_CC:     rd_mux = {24'h0, cc};
      ADDR_PEND:   rd_mux = {{(32-NUM_VEC-1){1'b0}}, trap_pend, request};
      ADDR_ENABLE: rd_mux = {{(32-NUM_VEC){1'b0}}, enable};
      ADDR_WAKE:   rd_mux = {{(32-NUM_VEC){1'b0}}, wake_cap};
      ADDR_EDGE:   rd_mux = {{(32-NUM_VEC){1'b0}}, edge_mode};
      ADDR_STATUS: rd_mux = {27'h0, state};
      default:     rd_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h0;
      O_RRESP <= RESP_OKAY;
    end else begin
      O_ARREADY <= !O_RVALID && !(I_ARVALID && O_ARREADY);
      if (I_ARVALID && O_ARREADY) begin
        O_RVALID <= 1'b1;
        O_RDATA <= rd_mux;
        O_RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (O_RVALID && I_RREADY) begin
        O_RVALID <= 1'b0;
      end
    end
  end

endmodule

/* design/nic_pkg.sv */
package nic_pkg;

  // ------------------------------------------------------------
  // Vectors and priority levels
  // ------------------------------------------------------------
  localparam int          NUM_VEC      = 14;
  localparam int          NUM_LEVELS   = 4;
  localparam logic [15:0] VEC_RESET    = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP     = 16'hFFFC;
  localparam logic [15:0] VEC_BASE     = 16'hFFFA;
  localparam logic [1:0]  LVL0_CODE    = 2'h2;
  localparam logic [1:0]  LVL1_CODE    = 2'h1;
  localparam logic [1:0]  LVL2_CODE    = 2'h0;
  localparam logic [1:0]  LVL3_CODE    = 2'h3;
  localparam int          CC_BIT_HIGH  = 5;
  localparam int          CC_BIT_LOW   = 3;
  localparam logic [7:0]  CC_RESET     = 8'hEA;
  localparam logic [7:0]  PRIO_RESET   = 8'hFF;
  localparam int          NUM_PRIO_REG = 4;

  // ------------------------------------------------------------
  // Register map (AXI4-Lite byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_PRIO0    = 8'h00;
  localparam logic [7:0] ADDR_CC       = 8'h10;
  localparam logic [7:0] ADDR_PEND     = 8'h14;
  localparam logic [7:0] ADDR_ENABLE   = 8'h18;
  localparam logic [7:0] ADDR_WAKE     = 8'h1C;
  localparam logic [7:0] ADDR_EDGE     = 8'h20;
  localparam logic [7:0] ADDR_STATUS   = 8'h24;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // Service states
  typedef enum logic [4:0] {
    ST_RESET  = 5'h01,
    ST_RUN    = 5'h02,
    ST_WAIT   = 5'h04,
    ST_STOP   = 5'h08,
    ST_VECTOR = 5'h10
  } svc_state_t;

  // CPU instruction-boundary events
  typedef struct packed {
    logic       boundary;
    logic       trap;
    logic       enable_int;
    logic       disable_int;
    logic       wait_for_interrupt_instr;
    logic       deep_stop;
    logic       return_from_interrupt;
    logic       pop_cc;
    logic [7:0] cc_value;
  } cpu_evt_t;

  // Vector request to the CPU
  typedef struct packed {
    logic        take;
    logic        stack;
    logic [15:0] addr;
    logic [3:0]  index;
  } vec_req_t;

endpackage

/* testbench/nested_priority_interrupt_controller_tb.sv */
`timescale 1ns/10ps
module nested_priority_interrupt_controller_tb;
  import nic_pkg::*;
  localparam logic [7:0] K_NOP = 8'h00, K_TRAP = 8'h40, K_EN = 8'h20;
  localparam logic [7:0] K_DIS = 8'h10, K_WFI = 8'h08, K_STOP = 8'h04;
  localparam logic [7:0] K_RETURN_FROM_INTERRUPT = 8'h02, K_POP = 8'h01;
  logic        clk = 0, rst_n = 0, wake;
  cpu_evt_t    evt;
  vec_req_t    vec, got;
  logic [13:0] preq = '0, pclr = '0, en, q;
  logic [55:0] pins = '0;
  logic [7:0]  cc, v, awaddr = '0, araddr = '0, prio [4];
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = '0, rdata, rd;
  logic [1:0]  bresp, rresp, rs, cur;
  int          n_fail = 0, checks = 0, w;

  initial forever #5 clk = ~clk;

  nic_cpu_model cpu_u (.i_clk(clk), .i_vec(vec), .o_evt(evt));

  nested_priority_interrupt_controller dut_u (
    .I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_CPU_EVT(evt),
    .I_PERIPH_REQ(preq), .I_PERIPH_CLEAR(pclr), .I_EXT_PINS(pins),
    .O_VEC(vec), .O_CC(cc), .O_WAKE(wake),
    .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid),
    .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
    .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
    .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp),
    .O_RVALID(rvalid), .I_RREADY(rready));

  // ------------------------------------------------
  // Reference model and bus tasks
  // ------------------------------------------------
  function automatic int rank(logic [1:0] c);
    return c == LVL0_CODE ? 0 : c == LVL1_CODE ? 1 : c == LVL2_CODE ? 2 : 3;
  endfunction
  function automatic logic [1:0] code(int i);
    return prio[i/4][2*(i%4)+:2];
  endfunction
  function automatic int winner(logic [13:0] r);
    int b = -1;
    for (int i = 0; i < NUM_VEC; i++)
      if (r[i] && en[i] && rank(code(i)) > rank(cur)
          && (b < 0 || rank(code(i)) > rank(code(b)))) b = i;
    return b;
  endfunction
  function automatic logic [7:0] merge(logic [7:0] o, logic [7:0] n);
    for (int f = 0; f < 8; f += 2)
      if (n[f+:2] != LVL0_CODE) o[f+:2] = n[f+:2];
    return o;
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    rs = bresp;
    if (a < ADDR_CC) prio[a[3:2]] = merge(prio[a[3:2]], d[7:0]);
    if (a == ADDR_ENABLE) en = d[13:0];
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
  endtask
  task automatic go(input logic [7:0] k, input logic [7:0] c = 8'h00);
    cpu_u.step(cpu_evt_t'({k, c}), $urandom_range(0, 2), got);
  endtask
  task automatic chk_take(input int x);
    if (x < 0) chk(got.take, 0);
    else begin
      chk({got.take, got.stack, got.index}, {2'b11, 4'(x)});
      chk(got.addr, VEC_BASE - 16'(2 * x));
      chk({cc[5], cc[3]}, code(x));
    end
  endtask
  task automatic pulse(input int p);
    pins[p] <= 1'b1;
    @(posedge clk);
    pins[p] <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Sized for about fifty thousand cycles of traffic
  initial begin
    #500000;
    n_fail++;
    close_out();
  end

  // ------------------------------------------------
  // Tests
  // ------------------------------------------------
  initial begin
    void'($urandom(32'h7458));
    for (int i = 0; i < 4; i++) prio[i] = PRIO_RESET;
    en = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk({vec.take, vec.stack, vec.index, vec.addr},
        {2'b10, 4'hF, VEC_RESET});
    chk({cc[5], cc[3]}, LVL3_CODE);
    rd_reg(ADDR_PRIO0);
    chk(rd, 32'hFF);
    rd_reg(8'h30);
    chk(rs, RESP_SLVERR);
    wr(ADDR_PRIO0, 32'hCF);
    wr(ADDR_PRIO0, 32'h64);
    chk(rs, RESP_OKAY);
    rd_reg(ADDR_PRIO0);
    chk(rd, {24'h0, prio[0]});
    $display("test reset_regs done");
    repeat (12) begin
      for (int r = 0; r < 4; r++) wr(ADDR_PRIO0 + 8'(4 * r), $urandom);
      wr(ADDR_ENABLE, $urandom);
      v = 8'($urandom);
      go(v[0] ? K_POP : K_RETURN_FROM_INTERRUPT, v);
      cur = {v[5], v[3]};
      chk({cc[5], cc[3]}, cur);
      q = 14'($urandom);
      preq <= q;
      w = winner(q);
      go(K_NOP);
      chk_take(w);
      preq <= '0;
    end
    $display("test arbitration done");
    wr(ADDR_ENABLE, 32'h3FFF);
    go(K_RETURN_FROM_INTERRUPT, 8'hE2);
    preq <= 14'h3FFF;
    go(K_TRAP);
    chk({got.take, got.stack, got.index}, {2'b11, 4'hE});
    chk({cc[5], cc[3]}, LVL3_CODE);
    preq <= '0;
    go(K_EN);
    chk({cc[5], cc[3]}, LVL0_CODE);
    go(K_DIS);
    chk({cc[5], cc[3]}, LVL3_CODE);
    $display("test trap done");
    wr(ADDR_EDGE, 32'h4);
    wr(ADDR_PRIO0, 32'hDF);
    for (int p = 0; p < 4; p++) begin
      pulse(8 + p);
      rd_reg(ADDR_PEND);
      chk(rd[2], 1);
      pclr[2] <= 1'b1;
      @(posedge clk);
      pclr[2] <= 1'b0;
      rd_reg(ADDR_PEND);
      chk(rd[2], 0);
    end
    pulse(9);
    go(K_EN);
    chk_take(2);
    rd_reg(ADDR_PEND);
    chk(rd[2], 0);
    $display("test edge done");
    wr(ADDR_EDGE, 32'h0);
    wr(ADDR_WAKE, 32'h8);
    wr(ADDR_ENABLE, 32'h18);
    wr(ADDR_PRIO0, 32'h7F);
    wr(ADDR_PRIO0 + 8'h04, 32'hFF);
    go(K_STOP);
    preq[4] <= 1'b1;
    repeat (6) @(posedge clk);
    chk(wake, 0);
    preq[3] <= 1'b1;
    for (int n = 0; n < 20 && wake !== 1'b1; n++) @(posedge clk);
    chk(wake, 1);
    go(K_NOP);
    chk_take(3);
    preq[3] <= 1'b0;
    go(K_NOP);
    chk_take(4);
    preq <= '0;
    go(K_WFI);
    preq[4] <= 1'b1;
    for (int n = 0; n < 20 && wake !== 1'b1; n++) @(posedge clk);
    chk(wake, 1);
    go(K_NOP);
    chk_take(4);
    preq <= '0;
    $display("test wake done");
    close_out();
  end
endmodule

/* testbench/nic_checker.sv */
`timescale 1ns/10ps
module nic_checker
  import nic_pkg::*;
(
  input wire logic       I_SYS_CLK,
  input wire logic       I_RESET_N,
  input wire cpu_evt_t   I_CPU_EVT,
  input wire vec_req_t   O_VEC,
  input wire logic [7:0] O_CC,
  input wire logic       O_BVALID,
  input wire logic       I_BREADY
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESET_N);
  wire [1:0] lvl = {O_CC[5], O_CC[3]};

  a_reset_entry: assert property (
    I_RESET_N && !$past(I_RESET_N) |=> O_VEC.take && !O_VEC.stack
    && O_VEC.index == 4'hF && O_VEC.addr == VEC_RESET && lvl == LVL3_CODE)
    else $error("reset entry wrong");
  a_take_pulse: assert property (
    O_VEC.take |=> !O_VEC.take)
    else $error("take longer than one cycle");
  a_take_bound: assert property (
    O_VEC.take && O_VEC.index != 4'hF |-> $past(I_CPU_EVT.boundary))
    else $error("take without boundary");
  a_vec_addr: assert property (
    O_VEC.take && O_VEC.index < 4'hE
    |-> O_VEC.addr == VEC_BASE - {11'h0, O_VEC.index, 1'b0})
    else $error("vector address wrong");
  a_mask_stack: assert property (
    O_VEC.take && O_VEC.index < 4'hE |-> O_VEC.stack)
    else $error("maskable entry not stacked");
  a_trap_entry: assert property (
    O_VEC.take && O_VEC.index == 4'hE
    |-> O_VEC.stack && O_VEC.addr == VEC_TRAP && lvl == LVL3_CODE)
    else $error("trap entry wrong");
  a_enable_lvl: assert property (
    I_CPU_EVT.boundary && I_CPU_EVT.enable_int
    |=> O_VEC.take || lvl == LVL0_CODE)
    else $error("enable level wrong");
  a_disable_lvl: assert property (
    I_CPU_EVT.boundary && I_CPU_EVT.disable_int |=> lvl == LVL3_CODE)
    else $error("disable level wrong");
  a_return_from_interrupt_lvl: assert property (
    I_CPU_EVT.boundary && I_CPU_EVT.return_from_interrupt |=> O_VEC.take
    || lvl == {$past(I_CPU_EVT.cc_value[5]), $past(I_CPU_EVT.cc_value[3])})
    else $error("return level wrong");
  a_lvl_cause: assert property (
    $changed(lvl) |-> O_VEC.take || $past(I_CPU_EVT.boundary))
    else $error("level changed without cause");
  a_bvalid_hold: assert property (
    O_BVALID && !I_BREADY |=> O_BVALID)
    else $error("write response dropped");
endmodule

bind nested_priority_interrupt_controller nic_checker chk_u (
  .I_SYS_CLK (I_SYS_CLK),
  .I_RESET_N (I_RESET_N),
  .I_CPU_EVT (I_CPU_EVT),
  .O_VEC     (O_VEC),
  .O_CC      (O_CC),
  .O_BVALID  (O_BVALID),
  .I_BREADY  (I_BREADY)
);

/* testbench/nic_cpu_model.sv */
`timescale 1ns/10ps
module nic_cpu_model
  import nic_pkg::*;
(
  input  wire logic     i_clk,
  input  wire vec_req_t i_vec,
  output cpu_evt_t      o_evt
);
  initial o_evt = '0;

  // Boundary lasts one cycle and stays low while a take is answered
  task automatic step(input cpu_evt_t e, input int idle,
                      output vec_req_t got);
    repeat (idle) @(posedge i_clk);
    @(posedge i_clk);
    e.boundary = 1'b1;
    o_evt <= e;
    @(posedge i_clk);
    o_evt <= '0;
    @(posedge i_clk);
    got = i_vec;
  endtask
endmodule
